// >>> logic/mstep_pkg.sv
/*
 * mstep_pkg: register map, field positions, reset values and output
 * step codes for the motor step control block.
 * Assumes a 32-bit AXI4-Lite bus and 8-bit registers in the low lane.
 */
package mstep_pkg;
	localparam int                ADDR_W           = 4;
	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_STEP_CTRL    = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_MODE_CTRL    = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_PHASE_STATE  = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_PRELOAD_VIEW = 4'hc;
	// motor_step_control fields
	localparam int                POS_REF_LO       = 6;
	localparam int                POS_EDGE_SEL     = 5;
	localparam int                POS_HW_DEMAG     = 4;
	localparam int                POS_SW_DEMAG     = 3;
	localparam int                POS_TOP_BIT      = 2;
	// mode control fields
	localparam int                POS_VC_SEL       = 0;
	localparam int                POS_SENSOR_SEL   = 1;
	localparam int                POS_DIRECT       = 2;
	localparam logic [7:0]        RST_REG8         = 8'h00;
	localparam logic [2:0]        RST_MODE         = 3'h0;
	// axi responses
	localparam logic [1:0]        RESP_OKAY        = 2'h0;
	localparam logic [1:0]        RESP_SLVERR      = 2'h2;
	// pwm step arrangement on pwm_step_mode_out
	typedef enum logic [2:0] {
		MSTEP_PWM_EVEN    = 3'b000,
		MSTEP_PWM_ODD     = 3'b001,
		MSTEP_PWM_ALT     = 3'b010,
		MSTEP_PWM_ALL     = 3'b011,
		MSTEP_PWM_NON_ALT = 3'b100
	} mstep_pwm_t;
endpackage

// >>> logic/mstep_ctrl.sv
/*
 * mstep_ctrl: motor step control register with preload stage, comparator
 * edge selection, demagnetization event gating and PWM step selection,
 * reached over AXI4-Lite.
 * Assumes commutation and demagnetization detect strobes are one-cycle
 * pulses on sys_clk_in; comparator input is asynchronous.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// How it works
// - motor_step_control is an 8-bit read/write register cleared to zero by reset.
// - bits 7:6 pick the comparator reference level 0.2V, 0.6V, 1.2V or 2.5V.
// - bit 5 at 0 detects zero crossings on the falling edge, at 1 on the rising edge.
// - hardware demagnetization events pass only while bit 4 is set.
// - software demagnetization events pass only while bit 3 is set.
// - bits 2:0 choose the PWM arrangement across each commutation step.
// - after demagnetization bits 1:0 pick even, odd, alternate or all active channels.
// - edge select, both demag enables and the top mode bit wait in preload until commutation.
// - only the top mode bit is preloaded; bits 1:0 act as soon as written.
// - the voltage/current bit picks voltage mode at 0 and current mode at 1.
// - sensor select at 1 runs with sensors and ignores the top mode bit.
// - in direct access mode a phase state write moves all preload values at once.
`timescale 1ns/1ns
module mstep_ctrl (
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire logic [mstep_pkg::ADDR_W-1:0] s_awaddr_in,
	input  wire logic                        s_awvalid_in,
	output logic                             s_awready_out,
	input  wire logic [31:0]                 s_wdata_in,
	input  wire logic [3:0]                  s_wstrb_in,
	input  wire logic                        s_wvalid_in,
	output logic                             s_wready_out,
	output logic [1:0]                       s_bresp_out,
	output logic                             s_bvalid_out,
	input  wire logic                        s_bready_in,
	input  wire logic [mstep_pkg::ADDR_W-1:0] s_araddr_in,
	input  wire logic                        s_arvalid_in,
	output logic                             s_arready_out,
	output logic [31:0]                      s_rdata_out,
	output logic [1:0]                       s_rresp_out,
	output logic                             s_rvalid_out,
	input  wire logic                        s_rready_in,
	input  wire logic                        commutation_in,
	input  wire logic                        comparator_in,
	input  wire logic                        hw_demag_det_in,
	input  wire logic                        sw_demag_req_in,
	output logic [1:0]                       ref_threshold_sel_out,
	output logic                             zero_cross_out,
	output logic                             demag_event_out,
	output logic                             after_demag_out,
	output logic [2:0]                       pwm_step_mode_out
);
	import mstep_pkg::*;

	logic [ADDR_W-1:0] aw_addr;
	logic              aw_held;
	logic [7:0]        w_data;
	logic              w_strb0;
	logic              w_held;
	logic              next_aw_held;
	logic              next_w_held;
	logic              next_bvalid;
	logic              wr_commit;
	logic              wr_hit;
	logic              next_rvalid;
	logic [7:0]        rd_val;
	logic              rd_hit;

	// software visible state
	logic [1:0]        ref_threshold_sel;
	logic [1:0]        post_demag_pwm_sel;
	logic [3:0]        pre_bits;
	logic [3:0]        act_bits;
	logic              voltage_current_sel;
	logic              sensor_select;
	logic              direct_access;
	logic [7:0]        phase_state_reg;
	logic              load_preload;

	logic              cmp_s1;
	logic              cmp_s2;
	logic              cmp_s3;
	logic              after_demag;
	logic              demag_now;
	mstep_pwm_t        next_pwm;

	wire logic zero_cross_edge_sel = act_bits[3];
	wire logic hw_demag_enable     = act_bits[2];
	wire logic sw_demag_enable     = act_bits[1];
	wire logic step_mode_top_bit   = act_bits[0];

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		addr_known = (a == OFF_STEP_CTRL) || (a == OFF_MODE_CTRL) ||
			(a == OFF_PHASE_STATE) || (a == OFF_PRELOAD_VIEW);
	endfunction

	// write channel: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held | (s_awvalid_in & s_awready_out);
		next_w_held  = w_held | (s_wvalid_in & s_wready_out);
		wr_commit    = aw_held & w_held & ~s_bvalid_out;
		if (wr_commit) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
		end
		next_bvalid = wr_commit | (s_bvalid_out & ~s_bready_in);
		wr_hit      = wr_commit & w_strb0;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= RST_REG8;
			w_strb0       <= 1'b0;
			s_awready_out <= 1'b0;
			s_wready_out  <= 1'b0;
			s_bvalid_out  <= 1'b0;
			s_bresp_out   <= RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			s_awready_out <= ~next_aw_held & ~next_bvalid;
			s_wready_out  <= ~next_w_held & ~next_bvalid;
			s_bvalid_out  <= next_bvalid;
			if (s_awvalid_in && s_awready_out) begin
				aw_addr <= s_awaddr_in;
			end
			if (s_wvalid_in && s_wready_out) begin
				w_data  <= s_wdata_in[7:0];
				w_strb0 <= s_wstrb_in[0];
			end
			if (wr_commit) begin
				s_bresp_out <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// direct access load on phase state write
	always_comb begin
		load_preload = direct_access ? (wr_hit && aw_addr == OFF_PHASE_STATE) : commutation_in;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ref_threshold_sel   <= RST_REG8[7:6];
			post_demag_pwm_sel  <= RST_REG8[1:0];
			pre_bits            <= RST_REG8[5:2];
			voltage_current_sel <= RST_MODE[POS_VC_SEL];
			sensor_select       <= RST_MODE[POS_SENSOR_SEL];
			direct_access       <= RST_MODE[POS_DIRECT];
			phase_state_reg     <= RST_REG8;
		end else if (wr_hit) begin
			case (aw_addr)
				OFF_STEP_CTRL: begin
					ref_threshold_sel  <= w_data[POS_REF_LO +: 2];
					// low mode bits act at once
					post_demag_pwm_sel <= w_data[1:0];
					pre_bits           <= w_data[POS_EDGE_SEL:POS_TOP_BIT];
				end
				OFF_MODE_CTRL: begin
					voltage_current_sel <= w_data[POS_VC_SEL];
					sensor_select       <= w_data[POS_SENSOR_SEL];
					direct_access       <= w_data[POS_DIRECT];
				end
				OFF_PHASE_STATE: begin
					phase_state_reg <= w_data;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			act_bits <= RST_REG8[5:2];
		end else if (load_preload) begin
			act_bits <= pre_bits;
		end
	end

	// step control reads return active values, not the preload; the preload view returns pre_bits
	always_comb begin
		rd_hit = 1'b1;
		case (s_araddr_in)
			OFF_STEP_CTRL:    rd_val = {ref_threshold_sel, act_bits, post_demag_pwm_sel};
			OFF_MODE_CTRL:    rd_val = {5'h00, direct_access, sensor_select, voltage_current_sel};
			OFF_PHASE_STATE:  rd_val = phase_state_reg;
			OFF_PRELOAD_VIEW: rd_val = {2'h0, pre_bits, 2'h0};
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		next_rvalid = (s_arvalid_in & s_arready_out) | (s_rvalid_out & ~s_rready_in);
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			s_arready_out <= 1'b0;
			s_rvalid_out  <= 1'b0;
			s_rdata_out   <= 32'h0000_0000;
			s_rresp_out   <= RESP_OKAY;
		end else begin
			s_arready_out <= ~next_rvalid;
			s_rvalid_out  <= next_rvalid;
			if (s_arvalid_in && s_arready_out) begin
				s_rdata_out <= {24'h00_0000, rd_val};
				s_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// comparator is asynchronous: two stages before use
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
		end else begin
			cmp_s1 <= comparator_in;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
		end
	end

	always_comb begin
		demag_now = (hw_demag_det_in & hw_demag_enable) | (sw_demag_req_in & sw_demag_enable);
	end

	always_comb begin
		if (after_demag || sensor_select) begin
			// after demag, or whole step with sensors
			next_pwm = mstep_pwm_t'({1'b0, post_demag_pwm_sel});
		end else if (!voltage_current_sel) begin
			next_pwm = step_mode_top_bit ? MSTEP_PWM_ALT : MSTEP_PWM_NON_ALT;
		end else begin
			next_pwm = step_mode_top_bit ? MSTEP_PWM_ODD : MSTEP_PWM_EVEN;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			after_demag           <= 1'b0;
			after_demag_out       <= 1'b0;
			demag_event_out       <= 1'b0;
			zero_cross_out        <= 1'b0;
			ref_threshold_sel_out <= RST_REG8[7:6];
			pwm_step_mode_out     <= MSTEP_PWM_EVEN;
		end else begin
			// a new step restarts before demag, so commutation wins
			if (commutation_in) begin
				after_demag <= 1'b0;
			end else if (demag_now) begin
				after_demag <= 1'b1;
			end
			after_demag_out <= after_demag;
			demag_event_out <= demag_now;
			zero_cross_out <= zero_cross_edge_sel ? (cmp_s2 & ~cmp_s3) : (~cmp_s2 & cmp_s3);
			ref_threshold_sel_out <= ref_threshold_sel;
			pwm_step_mode_out     <= next_pwm;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	a_reset_clears_reg: assert property ($rose(rstn_in) |-> act_bits == 4'h0 && pre_bits == 4'h0)
		else $error("register not cleared by reset");
	a_ref_follows_reg: assert property (##1 ref_threshold_sel_out == $past(ref_threshold_sel))
		else $error("reference select not following register");
	a_edge_rising_ok: assert property (zero_cross_out |-> $past(zero_cross_edge_sel) == $past(cmp_s2))
		else $error("zero crossing on wrong edge");
	a_hw_demag_pass: assert property (hw_demag_det_in && hw_demag_enable |=> demag_event_out)
		else $error("enabled hardware demag lost");
	a_demag_needs_en: assert property (demag_event_out |-> $past(demag_now))
		else $error("demag event while disabled");
	a_sw_blocked_off: assert property (sw_demag_req_in && !sw_demag_enable && !hw_demag_det_in
		|=> !demag_event_out)
		else $error("disabled software demag passed");
	a_after_d_mode: assert property (after_demag |=> pwm_step_mode_out == {1'b0, $past(post_demag_pwm_sel)})
		else $error("after demag mode wrong");
	a_preload_waits: assert property (!load_preload |=> act_bits == $past(act_bits))
		else $error("active bits changed without load");
	a_preload_moves: assert property (commutation_in && !direct_access |=> act_bits == $past(pre_bits))
		else $error("preload not moved on commutation");
	a_low_bits_now: assert property (wr_hit && aw_addr == OFF_STEP_CTRL
		|=> post_demag_pwm_sel == $past(w_data[1:0]))
		else $error("low mode bits delayed");
	a_direct_load: assert property (direct_access && wr_hit && aw_addr == OFF_PHASE_STATE
		|=> act_bits == $past(pre_bits))
		else $error("direct access load missing");
	a_sensor_ignores: assert property (sensor_select && !after_demag && $stable(sensor_select)
		|=> pwm_step_mode_out[2] == 1'b0)
		else $error("sensor mode used top bit");
	a_current_before_d: assert property (!after_demag && !sensor_select && voltage_current_sel
		|=> pwm_step_mode_out == {2'b00, $past(step_mode_top_bit)})
		else $error("current mode before demag wrong");
	a_voltage_before_d: assert property (!after_demag && !sensor_select && !voltage_current_sel
		|=> pwm_step_mode_out == ($past(step_mode_top_bit) ? MSTEP_PWM_ALT : MSTEP_PWM_NON_ALT))
		else $error("voltage mode before demag wrong");

	c_write_done: cover property (s_bvalid_out && s_bready_in);
	c_commutation_load: cover property (commutation_in && pre_bits != act_bits);
	c_demag_then_comm: cover property (demag_event_out ##[1:20] commutation_in);
	c_zero_cross: cover property (zero_cross_out);
endmodule

// >>> verif/motor_step_config_register_test.sv
/*
 * motor_step_config_register_test: self-checking bench for mstep_ctrl,
 * register access over AXI4-Lite, event pulses and step outputs.
 * Assumes mstep_pkg is compiled first and one 4 ns clock.
 */
`timescale 1ns/1ns
module motor_step_config_register_test;
	import mstep_pkg::*;
	logic        sys_clk, rstn, awv, wv, bre, arv, rre, comm, cmp, hwd, swd;
	logic [3:0]  awa, ara, wst;
	logic [31:0] wd;
	wire         awr, wrd, bv, arr, rv, zc, dev, ad;
	wire  [1:0]  br, rr, ref_sel;
	wire  [31:0] rdat;
	wire  [2:0]  pwm;
	int          bad_count, checks_done, dcnt, zcnt, k;
	mstep_pwm_t  pre_exp [4] = '{MSTEP_PWM_NON_ALT, MSTEP_PWM_ALT, MSTEP_PWM_EVEN, MSTEP_PWM_ODD};

	mstep_ctrl DUT (.sys_clk_in(sys_clk), .rstn_in(rstn), .s_awaddr_in(awa), .s_awvalid_in(awv),
		.s_awready_out(awr), .s_wdata_in(wd), .s_wstrb_in(wst), .s_wvalid_in(wv), .s_wready_out(wrd),
		.s_bresp_out(br), .s_bvalid_out(bv), .s_bready_in(bre), .s_araddr_in(ara), .s_arvalid_in(arv),
		.s_arready_out(arr), .s_rdata_out(rdat), .s_rresp_out(rr), .s_rvalid_out(rv), .s_rready_in(rre),
		.commutation_in(comm), .comparator_in(cmp), .hw_demag_det_in(hwd), .sw_demag_req_in(swd),
		.ref_threshold_sel_out(ref_sel), .zero_cross_out(zc), .demag_event_out(dev),
		.after_demag_out(ad), .pwm_step_mode_out(pwm));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// pulses counted here so short strobes are never missed
	always @(posedge sys_clk) begin
		if (dev === 1'b1)
			dcnt++;
		if (zc === 1'b1)
			zcnt++;
	end

	task automatic give_verdict;
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 100) begin
			bad_count++;
			$display("ERROR t=%0t bus wait timed out", $time);
			give_verdict;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY,
		input logic [3:0] s = 4'h1);
		int   n;
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		@(posedge sys_clk);
		awa <= a;
		awv <= 1'b1;
		wd <= {24'h0, d};
		wst <= s;
		wv <= 1'b1;
		bre <= 1'b1;
		while ((pa || pw) && n < 50) begin
			@(posedge sys_clk);
			n++;
			if (pa && awr === 1'b1) begin
				awv <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wrd === 1'b1) begin
				wv <= 1'b0;
				pw = 1'b0;
			end
		end
		while (bv !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		tmo(n);
		bre <= 1'b0;
		chk(br, er);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge sys_clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (arr !== 1'b1 && n < 50);
		arv <= 1'b0;
		while (rv !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		tmo(n);
		rre <= 1'b0;
		chk(rdat, exp);
		chk(rr, er);
	endtask

	// 0 commutation, 1 hardware demag, 2 software demag
	task automatic pulse(input int w);
		@(posedge sys_clk);
		comm <= (w == 0);
		hwd <= (w == 1);
		swd <= (w == 2);
		@(posedge sys_clk);
		comm <= 1'b0;
		hwd <= 1'b0;
		swd <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic cmp_to(input logic v);
		@(posedge sys_clk);
		cmp <= v;
		repeat (6) @(posedge sys_clk);
	endtask

	initial begin
		{rstn, awv, wv, bre, arv, rre, comm, cmp, hwd, swd} = '0;
		{awa, ara, wst, wd} = '0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(OFF_STEP_CTRL, 32'h0);
		for (int v = 0; v < 4; v++) begin
			wr(OFF_STEP_CTRL, 8'(v << 6));
			repeat (2) @(posedge sys_clk);
			chk(ref_sel, 32'(v));
			rd(OFF_STEP_CTRL, 32'(v << 6));
		end
		// strobe off and unmapped address must leave the register alone
		wr(OFF_STEP_CTRL, 8'h3f, RESP_OKAY, 4'h0);
		wr(4'h2, 8'h3f, RESP_SLVERR);
		rd(4'h2, 32'h0, RESP_SLVERR);
		rd(OFF_STEP_CTRL, 32'hc0);
		wr(OFF_STEP_CTRL, 8'h3f);
		rd(OFF_STEP_CTRL, 32'h03);
		rd(OFF_PRELOAD_VIEW, 32'h3c);
		chk(pwm, MSTEP_PWM_NON_ALT);
		pulse(0);
		rd(OFF_STEP_CTRL, 32'h3f);
		chk(pwm, MSTEP_PWM_ALT);
		for (int s = 0; s < 4; s++) begin
			wr(OFF_STEP_CTRL, 8'(8'h18 | s));
			pulse(0);
			chk(pwm, MSTEP_PWM_NON_ALT);
			k = dcnt;
			pulse(1 + s % 2);
			chk(dcnt, k + 1);
			chk(ad, 1'b1);
			chk(pwm, 32'(s));
		end
		wr(OFF_STEP_CTRL, 8'h00);
		pulse(0);
		k = dcnt;
		pulse(1);
		pulse(2);
		chk(dcnt, k);
		chk(ad, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(OFF_MODE_CTRL, 8'(m >> 1));
			rd(OFF_MODE_CTRL, 32'(m >> 1));
			wr(OFF_STEP_CTRL, 8'(((m & 1) << 2) | 3));
			pulse(0);
			chk(pwm, pre_exp[m]);
		end
		// sensor mode ignores the top bit before demag
		wr(OFF_MODE_CTRL, 8'h02);
		rd(OFF_MODE_CTRL, 32'h02);
		wr(OFF_STEP_CTRL, 8'h05);
		pulse(0);
		chk(pwm, MSTEP_PWM_ODD);
		wr(OFF_MODE_CTRL, 8'h00);
		wr(OFF_STEP_CTRL, 8'h00);
		pulse(0);
		k = zcnt;
		cmp_to(1'b1);
		chk(zcnt, k);
		cmp_to(1'b0);
		chk(zcnt, k + 1);
		wr(OFF_STEP_CTRL, 8'h20);
		pulse(0);
		cmp_to(1'b1);
		chk(zcnt, k + 2);
		cmp_to(1'b0);
		chk(zcnt, k + 2);
		// direct access: commutation no longer loads, phase write does
		wr(OFF_MODE_CTRL, 8'h04);
		rd(OFF_MODE_CTRL, 32'h04);
		wr(OFF_STEP_CTRL, 8'h10);
		pulse(0);
		rd(OFF_STEP_CTRL, 32'h20);
		wr(OFF_PHASE_STATE, 8'h55);
		rd(OFF_STEP_CTRL, 32'h10);
		rd(OFF_PHASE_STATE, 32'h55);
		// mid-run reset with no transfer open must clear every stored field
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(OFF_STEP_CTRL, 32'h0);
		rd(OFF_PRELOAD_VIEW, 32'h0);
		rd(OFF_MODE_CTRL, 32'h0);
		rd(OFF_PHASE_STATE, 32'h0);
		chk(pwm, MSTEP_PWM_NON_ALT);
		give_verdict;
	end
endmodule
